//--- include/pivmc_pkg.sv
// Package with register map, field positions, vectors and carrier types.
package pivmc_pkg;
	// Register indices as printed; byte address is four times the index.
	localparam logic [15:0] IDX_MODE_CONTROL = 16'h2015;
	localparam logic [15:0] IDX_PERIPHERAL_VECTOR = 16'h201C;
	localparam logic [15:0] IDX_PERIPHERAL_MASK = 16'h201D;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'h2050;
	localparam logic [15:0] IDX_IRQ_ENABLE = 16'h2051;
	localparam logic [17:0] ADDR_MODE_CONTROL = {IDX_MODE_CONTROL, 2'b00};
	localparam logic [17:0] ADDR_PERIPHERAL_VECTOR = {IDX_PERIPHERAL_VECTOR, 2'b00};
	localparam logic [17:0] ADDR_PERIPHERAL_MASK = {IDX_PERIPHERAL_MASK, 2'b00};
	localparam logic [17:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [17:0] ADDR_IRQ_ENABLE = {IDX_IRQ_ENABLE, 2'b00};
	// Source count and vector table layout.
	localparam int NUM_SOURCES = 11;
	localparam logic [15:0] VECTOR_BASE = 16'h0030;
	localparam logic [15:0] VECTOR_LAST = 16'h0058;
	localparam logic [15:0] VECTOR_STEP = 16'h0004;
	localparam logic [15:0] CORE_ENTRY_VECTOR = 16'h0004;
	// Mode control field positions and reset values.
	localparam int MODE_WIDTH = 9;
	localparam int BIT_PWM_DOUBLE_UPDATE = 6;
	localparam int BIT_RECEIVE_PIN_SELECT = 4;
	localparam int BIT_UART_ROUTE_ENABLE = 5;
	localparam int BIT_AUX_OFFSET_MODE = 8;
	localparam logic [8:0] MODE_WRITABLE = 9'h170;
	localparam logic [8:0] MODE_RESET = 9'h000;
	localparam logic [10:0] MASK_RESET = 11'h000;
	// Event status bits.
	localparam int EVT_VECTOR_LOADED = 0;
	localparam int EVT_VECTOR_READ = 1;
	localparam logic [1:0] EVT_RESET = 2'h0;
	// AXI4-Lite response codes.
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Serial port pin group toward the pads and the core.
	typedef struct packed {
		logic receivePinA;
		logic receivePinB;
		logic frameSyncPadIn;
		logic coreFlagOutput;
	} pivmc_sport_in_t;
	typedef struct packed {
		logic receiveDataToCore;
		logic receiveFrameSyncInput;
		logic frameSyncPadOut;
		logic frameSyncPadOe;
	} pivmc_sport_out_t;
	// Sequencer states.
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_HELD = 2'b01
	} pivmc_seq_state_t;
	// Next vector for a one-hot-or-more pending word: lowest index wins.
	function automatic logic [15:0] pick_vector(input logic [10:0] pending);
		logic [15:0] vec;
		vec = VECTOR_BASE;
		for (int i = NUM_SOURCES - 1; i >= 0; i--)
		begin
			if (pending[i])
			begin
				vec = VECTOR_BASE + 16'(i) * VECTOR_STEP;
			end
		end
		return vec;
	endfunction
endpackage

//--- src/pivmc_sequencer.sv
// Peripheral interrupt sequencer holding one vector until the core reads it.
`timescale 1ns/100ps
`default_nettype none
module pivmc_sequencer
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Sources and mask.
	input wire logic [10:0] sourceRequest,
	input wire logic [10:0] sourceMask,
	// Vector read strobe from the bus.
	input wire logic vectorRead,
	// Results.
	output logic [15:0] vectorOut,
	output logic coreRequest,
	output logic loadedPulse,
	output logic [10:0] pendingOut
);
	import pivmc_pkg::*;
	logic [10:0] pending_ff;
	logic [15:0] vector_ff;
	logic loaded_ff;
	pivmc_seq_state_t state_ff;
	logic [10:0] nxt_pending;
	logic [10:0] eligible;
	logic takeNow;
	logic [3:0] takeIdx;

	// Gate pending sources with the mask and decide on a load.
	always_comb
	begin
		eligible = pending_ff & sourceMask;
		takeNow = (state_ff == SEQ_IDLE) && (eligible != 11'h000);
		takeIdx = 4'((pick_vector(eligible) - VECTOR_BASE) >> 2);
		nxt_pending = pending_ff | sourceRequest;
		if (takeNow)
		begin
			nxt_pending[takeIdx] = sourceRequest[takeIdx];
		end
	end

	// Latch incoming requests until they are vectored.
	always_ff @(posedge clock)
	begin
		if (rst)
			pending_ff <= 11'h000;
		else
			pending_ff <= nxt_pending;
	end

	// Load the highest-priority vector and hold it until read.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_ff <= SEQ_IDLE;
			vector_ff <= VECTOR_BASE;
			loaded_ff <= 1'b0;
		end
		else
		begin
			loaded_ff <= takeNow;
			case (state_ff)
				SEQ_IDLE:
				begin
					if (takeNow)
					begin
						vector_ff <= pick_vector(eligible);
						state_ff <= SEQ_HELD;
					end
				end
				SEQ_HELD:
				begin
					if (vectorRead)
						state_ff <= SEQ_IDLE;
				end
				default:
					state_ff <= SEQ_IDLE;
			endcase
		end
	end

	// One request per loaded vector; none until the read releases it.
	assign coreRequest = loaded_ff;
	assign loadedPulse = loaded_ff;
	assign vectorOut = vector_ff;
	assign pendingOut = pending_ff;
endmodule
`default_nettype wire

//--- src/pivmc_sport_mux.sv
// Routing of serial port one receive and frame sync pins.
`timescale 1ns/100ps
`default_nettype none
module pivmc_sport_mux
(
	// Mode bits.
	input wire logic receivePinSelect,
	input wire logic uartRouteEnable,
	// Pins and core signals.
	input wire pivmc_pkg::pivmc_sport_in_t sportIn,
	output pivmc_pkg::pivmc_sport_out_t sportOut
);
	import pivmc_pkg::*;
	// Select the data pin and the frame sync source.
	always_comb
	begin
		sportOut.receiveDataToCore = receivePinSelect ? sportIn.receivePinB
			: sportIn.receivePinA;
		sportOut.receiveFrameSyncInput = uartRouteEnable ? sportIn.receivePinA
			: sportIn.frameSyncPadIn;
		sportOut.frameSyncPadOut = sportIn.coreFlagOutput;
		sportOut.frameSyncPadOe = uartRouteEnable;
	end
endmodule
`default_nettype wire

//--- src/pivmc_top.sv
// Peripheral interrupt vectoring and mode control with an AXI4-Lite slave.
// Behaviour
// - Eleven peripheral sources feed one vectored request.
// - Highest-priority unmasked pending source's vector gets loaded.
// - Loaded vector holds until the core reads it.
// - No new request before the vector read.
// - Vectors span 0x0030 to 0x0058, one each.
// - Bit four picks receive pin A or B.
// - Receive select resets to zero, pin A.
// - UART enable routes pin A to frame sync.
// - UART enable drives core flag to pad.
// - Mode bits select main and auxiliary PWM modes.
`timescale 1ns/100ps
`default_nettype none
module pivmc_top
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// AXI4-Lite write address channel.
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data channel.
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response channel.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address channel.
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data channel.
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral interrupt sources.
	input wire logic [10:0] sourceRequest,
	// Vectored request to the core.
	output logic coreRequest,
	// Event interrupt output.
	output logic irqOut,
	// Serial port pins.
	input wire pivmc_pkg::pivmc_sport_in_t sportIn,
	output pivmc_pkg::pivmc_sport_out_t sportOut,
	// PWM mode selects.
	output logic pwmDoubleUpdate,
	output logic auxOffsetMode
);
	import pivmc_pkg::*;
	// Register file, channel holding registers and decode results.
	logic [8:0] mode_ff;
	logic [10:0] mask_ff;
	logic [1:0] status_ff;
	logic [1:0] enable_ff;
	logic [31:0] awaddr_ff;
	logic awHeld_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic wHeld_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic doWrite;
	logic doRead;
	logic vectorRead;
	logic loadedPulse;
	logic [15:0] vectorValue;
	logic [10:0] pendingValue;
	logic [31:0] readWord;
	logic readHit;
	logic writeHit;
	logic writeMode;
	logic writeMask;
	logic writeStatus;
	logic writeEnable;
	logic [1:0] statusClear;
	logic [1:0] statusSet;

	// Register address match on the aligned word.
	// Upper address bits must be zero, so no alias of the map answers.
	function automatic logic addr_is(input logic [31:0] addr, input logic [17:0] target);
		return (addr[31:18] == 14'h0000) && (addr[17:2] == target[17:2]);
	endfunction

	// Write channels are taken independently and held until the response.
	// Holding both channels until the response keeps a second write from overtaking the first.
	assign s_axi_awready = !awHeld_ff && !bvalid_ff;
	assign s_axi_wready = !wHeld_ff && !bvalid_ff;
	assign doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;

	// Per-register write strobes, high only in the cycle the write lands.
	assign writeMode = doWrite && addr_is(awaddr_ff, ADDR_MODE_CONTROL);
	assign writeMask = doWrite && addr_is(awaddr_ff, ADDR_PERIPHERAL_MASK);
	assign writeStatus = doWrite && addr_is(awaddr_ff, ADDR_IRQ_STATUS) && wstrb_ff[0];
	assign writeEnable = doWrite && addr_is(awaddr_ff, ADDR_IRQ_ENABLE) && wstrb_ff[0];

	// Capture the write address.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			awHeld_ff <= 1'b0;
			awaddr_ff <= 32'h00000000;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			awHeld_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
		end
		else if (doWrite)
			awHeld_ff <= 1'b0;
	end

	// Capture the write data.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wHeld_ff <= 1'b0;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			wHeld_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
		end
		else if (doWrite)
			wHeld_ff <= 1'b0;
	end

	// Decode the write target.
	always_comb
	begin
		writeHit = addr_is(awaddr_ff, ADDR_MODE_CONTROL) || addr_is(awaddr_ff, ADDR_PERIPHERAL_MASK)
			|| addr_is(awaddr_ff, ADDR_IRQ_STATUS) || addr_is(awaddr_ff, ADDR_IRQ_ENABLE)
			|| addr_is(awaddr_ff, ADDR_PERIPHERAL_VECTOR);
	end

	// Write response.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end
		else if (doWrite)
		begin
			bvalid_ff <= 1'b1;
			bresp_ff <= writeHit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_ff <= 1'b0;
	end
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// Mode control register; only bits 8 and 6 to 4 store.
	always_ff @(posedge clock)
	begin
		if (rst)
			mode_ff <= MODE_RESET;
		else if (writeMode)
		begin
			if (wstrb_ff[0])
				mode_ff[7:0] <= wdata_ff[7:0] & MODE_WRITABLE[7:0];
			if (wstrb_ff[1])
				mode_ff[8] <= wdata_ff[8] & MODE_WRITABLE[8];
		end
	end

	// Peripheral mask register.
	always_ff @(posedge clock)
	begin
		if (rst)
			mask_ff <= MASK_RESET;
		else if (writeMask)
		begin
			if (wstrb_ff[0])
				mask_ff[7:0] <= wdata_ff[7:0];
			if (wstrb_ff[1])
				mask_ff[10:8] <= wdata_ff[10:8];
		end
	end

	// Event enable register.
	always_ff @(posedge clock)
	begin
		if (rst)
			enable_ff <= EVT_RESET;
		else if (writeEnable)
			enable_ff <= wdata_ff[1:0];
	end

	// Clear and set terms of the event status; a set in the same cycle wins.
	always_comb
	begin
		statusClear = writeStatus ? wdata_ff[1:0] : 2'h0;
		statusSet = 2'h0;
		statusSet[EVT_VECTOR_LOADED] = loadedPulse;
		statusSet[EVT_VECTOR_READ] = vectorRead;
	end

	// Sticky event status, cleared by writing a one.
	always_ff @(posedge clock)
	begin
		if (rst)
			status_ff <= EVT_RESET;
		else
			status_ff <= (status_ff & ~statusClear) | statusSet;
	end
	// The event line is a level, high while any enabled status bit is set.
	assign irqOut = |(status_ff & enable_ff);

	// Read channel: one read under way at a time.
	// The vector is released at the address handshake; the data returned are that vector.
	assign s_axi_arready = !rvalid_ff;
	assign doRead = s_axi_arvalid && s_axi_arready;
	assign vectorRead = doRead && addr_is(s_axi_araddr, ADDR_PERIPHERAL_VECTOR);

	// Read data multiplexer.
	// The status word also shows the sources still pending, so masked ones stay visible.
	always_comb
	begin
		readWord = 32'h00000000;
		readHit = 1'b1;
		if (addr_is(s_axi_araddr, ADDR_MODE_CONTROL))
			readWord = {23'h000000, mode_ff};
		else if (addr_is(s_axi_araddr, ADDR_PERIPHERAL_VECTOR))
			readWord = {16'h0000, vectorValue};
		else if (addr_is(s_axi_araddr, ADDR_PERIPHERAL_MASK))
			readWord = {21'h000000, mask_ff};
		else if (addr_is(s_axi_araddr, ADDR_IRQ_STATUS))
			readWord = {19'h00000, pendingValue, status_ff};
		else if (addr_is(s_axi_araddr, ADDR_IRQ_ENABLE))
			readWord = {30'h00000000, enable_ff};
		else
			readHit = 1'b0;
	end

	// Read response register.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= RESP_OKAY;
		end
		else if (doRead)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff <= readWord;
			rresp_ff <= readHit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_ff <= 1'b0;
	end
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// Interrupt sequencer.
	// Masked sources stay pending inside the sequencer until their mask bit is set.
	pivmc_sequencer u_seq
	(
		.clock(clock),
		.rst(rst),
		.sourceRequest(sourceRequest),
		.sourceMask(mask_ff),
		.vectorRead(vectorRead),
		.vectorOut(vectorValue),
		.coreRequest(coreRequest),
		.loadedPulse(loadedPulse),
		.pendingOut(pendingValue)
	);

	// Serial port pin routing.
	// Routing is combinational, so the pins follow a mode write in the next cycle.
	pivmc_sport_mux u_mux
	(
		.receivePinSelect(mode_ff[BIT_RECEIVE_PIN_SELECT]),
		.uartRouteEnable(mode_ff[BIT_UART_ROUTE_ENABLE]),
		.sportIn(sportIn),
		.sportOut(sportOut)
	);

	// PWM mode selects straight from the register.
	// Only the selects live here; the PWM units that use them sit outside this block.
	assign pwmDoubleUpdate = mode_ff[BIT_PWM_DOUBLE_UPDATE];
	assign auxOffsetMode = mode_ff[BIT_AUX_OFFSET_MODE];
endmodule
`default_nettype wire

//--- verif/pivmc_core_model.sv
// Behavioural core that owes one vector read per vectored request.
`timescale 1ns/100ps
`default_nettype none
module pivmc_core_model
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Request and read address channel.
	input wire logic coreRequest,
	input wire logic arHandshake,
	input wire logic [31:0] araddr,
	// Service owed by the handler at the entry vector.
	output logic serviceDue
);
	import pivmc_pkg::*;
	// A request enters at the shared entry and is closed by the vector read.
	always_ff @(posedge clock)
	begin
		if (rst)
			serviceDue <= 1'b0;
		else if (coreRequest)
			serviceDue <= 1'b1;
		else if (arHandshake && araddr == 32'(ADDR_PERIPHERAL_VECTOR))
			serviceDue <= 1'b0;
	end
endmodule
`default_nettype wire

//--- verif/pivmc_chk.sv
// Checker for vectoring, read channel and pin routing.
`timescale 1ns/100ps
`default_nettype none
module pivmc_chk
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Read channels.
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Core side and pins.
	input wire logic coreRequest,
	input wire logic irqOut,
	input wire pivmc_pkg::pivmc_sport_in_t sportIn,
	input wire pivmc_pkg::pivmc_sport_out_t sportOut
);
	import pivmc_pkg::*;
	logic held_ff;
	logic vecRd;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Vector read seen on the read address channel.
	assign vecRd = s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'(ADDR_PERIPHERAL_VECTOR);
	// Marks a delivered vector not yet read.
	always_ff @(posedge clock)
	begin
		if (rst || vecRd)
			held_ff <= 1'b0;
		else if (coreRequest)
			held_ff <= 1'b1;
	end
	property p_reqOnce;
		coreRequest |=> !coreRequest;
	endproperty
	a_reqOnce: assert property (p_reqOnce) else $error("request too long");
	property p_noReqHeld;
		held_ff |-> !coreRequest;
	endproperty
	a_noReqHeld: assert property (p_noReqHeld) else $error("request while held");
	property p_fsRoute;
		sportOut.frameSyncPadOe |-> sportOut.receiveFrameSyncInput == sportIn.receivePinA;
	endproperty
	a_fsRoute: assert property (p_fsRoute) else $error("frame sync not pin A");
	property p_fsNative;
		!sportOut.frameSyncPadOe |-> sportOut.receiveFrameSyncInput == sportIn.frameSyncPadIn;
	endproperty
	a_fsNative: assert property (p_fsNative) else $error("frame sync not pad");
	property p_flagPad;
		sportOut.frameSyncPadOe |-> sportOut.frameSyncPadOut == sportIn.coreFlagOutput;
	endproperty
	a_flagPad: assert property (p_flagPad) else $error("flag not on pad");
	property p_rdHold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rdHold: assert property (p_rdHold) else $error("read data moved");
	property p_vecRange;
		vecRd |=> s_axi_rdata[15:0] inside {[VECTOR_BASE:VECTOR_LAST]} && s_axi_rdata[1:0] == 2'h0;
	endproperty
	a_vecRange: assert property (p_vecRange) else $error("vector out of range");
	property p_resetQuiet;
		$fell(rst) |-> !irqOut && !coreRequest
			&& sportOut.receiveDataToCore == sportIn.receivePinA;
	endproperty
	a_resetQuiet: assert property (p_resetQuiet) else $error("busy after reset");
	c_req: cover property (coreRequest);
	c_vecRd: cover property (held_ff && vecRd);
	c_irq: cover property ($rose(irqOut));
endmodule
bind pivmc_top pivmc_chk u_chk (.clock, .rst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .coreRequest, .irqOut, .sportIn, .sportOut);
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the vectoring and mode control block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pivmc_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [31:0] awaddr = '0;
	logic [31:0] wdata = '0;
	logic [31:0] araddr = '0;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic bready = 1'b0;
	logic arv = 1'b0;
	logic rready = 1'b0;
	logic [10:0] src = '0;
	pivmc_sport_in_t pins = '0;
	pivmc_sport_out_t pout;
	logic awr, wr, bv, arr, rv, req, irq, due, dbl, aux;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rd, w;
	int n_mismatch = 0;
	int checks_done = 0;
	int pend = 0;
	int msk = 0;
	// Clock of 5 ns period.
	always #2.5 clock = ~clock;
	// Design and core model.
	pivmc_top dut (.clock, .rst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .sourceRequest(src),
		.coreRequest(req), .irqOut(irq), .sportIn(pins), .sportOut(pout),
		.pwmDoubleUpdate(dbl), .auxOffsetMode(aux));
	pivmc_core_model core (.clock, .rst, .coreRequest(req), .arHandshake(arv && arr),
		.araddr, .serviceDue(due));
	// Prints counts and the verdict, then stops.
	task automatic wrap_up;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Compares one result.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %0t got %0h exp %0h", $time, g, e);
		end
	endtask
	// Ends the run when a wait ran out.
	task automatic tmo(input bit ok);
		if (!ok)
		begin
			n_mismatch++;
			$display("MISMATCH %0t wait ran out", $time);
			wrap_up();
		end
	endtask
	// Bus write; handshakes are judged at the falling edge and released after the rising edge.
	task automatic wr32(input logic [15:0] idx, input logic [31:0] d);
		bit a;
		bit b;
		bit c;
		b = 0;
		@(posedge clock);
		awaddr <= {14'h0, idx, 2'h0};
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !b; n++)
		begin
			@(negedge clock);
			a = awv && awr;
			c = wv && wr;
			b = bready && bv;
			rs = bresp;
			@(posedge clock);
			if (a) awv <= 1'b0;
			if (c) wv <= 1'b0;
			if (b) bready <= 1'b0;
		end
		tmo(b);
	endtask
	// Bus read; ready is sometimes raised late to stall the answer.
	task automatic rd32(input logic [15:0] idx);
		bit a;
		bit r;
		r = 0;
		@(posedge clock);
		araddr <= {14'h0, idx, 2'h0};
		arv <= 1'b1;
		rready <= 1'($urandom);
		for (int n = 0; n < 50 && !r; n++)
		begin
			@(negedge clock);
			a = arv && arr;
			r = rready && rv;
			rd = rdata;
			rs = rresp;
			@(posedge clock);
			if (a) arv <= 1'b0;
			rready <= !r && (rready || 1'($urandom));
		end
		tmo(r);
	endtask
	// One-cycle source pulse, recorded in the pending model.
	task automatic pulse(input logic [10:0] v);
		src <= v;
		@(posedge clock);
		src <= 11'h000;
		pend = pend | v;
	endtask
	// Lowest unmasked pending index, or -1.
	function automatic int lowvec();
		int v;
		v = -1;
		for (int i = 10; i >= 0; i--)
			if ((pend & msk) & (1 << i)) v = i;
		return v;
	endfunction
	// Serves one request: new sources arrive while the vector is held.
	task automatic serve(input logic [10:0] f, input logic [10:0] d);
		int i;
		if ((pend & msk) == 0) pulse(f);
		i = lowvec();
		pend = pend & ~(1 << i);
		@(negedge clock);
		for (int n = 0; n < 50 && !due; n++) @(negedge clock);
		tmo(due);
		@(posedge clock);
		repeat ($urandom_range(0, 3)) @(posedge clock);
		pulse(d);
		rd32(IDX_PERIPHERAL_VECTOR);
		chk(rd, 32'h30 + 4 * i);
	endtask
	// Main sequence.
	initial
	begin
		void'($urandom(32'h8F6C));
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		wr32(IDX_PERIPHERAL_VECTOR, $urandom);
		chk(rs, RESP_OKAY);
		rd32(IDX_PERIPHERAL_VECTOR);
		chk(rd, 32'h30);
		rd32(IDX_MODE_CONTROL);
		chk(rd, 32'h0);
		rd32(IDX_PERIPHERAL_MASK);
		chk(rd, 32'h0);
		rd32(16'h2017);
		chk(rs, RESP_SLVERR);
		chk(rd, 32'h0);
		wr32(16'h2017, $urandom);
		chk(rs, RESP_SLVERR);
		// Every combination of the four mode bits, with random pin levels.
		for (int m = 0; m < 16; m++)
		begin
			w = ($urandom & 32'hFFFFFE8F) | 32'((m & 8) << 5) | 32'((m & 7) << 4);
			wr32(IDX_MODE_CONTROL, w);
			rd32(IDX_MODE_CONTROL);
			chk(rd, w & 32'h170);
			chk({aux, dbl}, {w[8], w[6]});
			repeat (3)
			begin
				pins <= 4'($urandom);
				@(negedge clock);
				chk(pout, {w[4] ? pins.receivePinB : pins.receivePinA,
					w[5] ? pins.receivePinA : pins.frameSyncPadIn, pins.coreFlagOutput, w[5]});
				@(posedge clock);
			end
		end
		// Sweep of all sources, then event interrupt set, clear and mask.
		wr32(IDX_IRQ_STATUS, 32'h3);
		wr32(IDX_IRQ_ENABLE, 32'h1);
		msk = 'h7FF;
		wr32(IDX_PERIPHERAL_MASK, msk);
		for (int i = 0; i < 11; i++) serve(11'(1 << i), 11'h000);
		chk(irq, 1'b1);
		wr32(IDX_IRQ_STATUS, 32'h1);
		chk(irq, 1'b0);
		wr32(IDX_IRQ_ENABLE, 32'h0);
		serve(11'h004, 11'h000);
		chk(irq, 1'b0);
		wr32(IDX_IRQ_ENABLE, 32'h1);
		chk(irq, 1'b1);
		// Random bursts, with late arrivals while a vector is held.
		repeat (12) serve(11'($urandom) | 11'h001, 11'($urandom));
		repeat (11) if (pend != 0) serve(11'h000, 11'h000);
		// A masked source stays pending until unmasked.
		msk = 'h7FE;
		wr32(IDX_PERIPHERAL_MASK, msk);
		pulse(11'h001);
		repeat (20) @(posedge clock);
		chk(due, 1'b0);
		rd32(IDX_IRQ_STATUS);
		chk(rd[12:2], pend);
		msk = 'h7FF;
		wr32(IDX_PERIPHERAL_MASK, msk);
		serve(11'h000, 11'h000);
		wrap_up();
	end
endmodule
`default_nettype wire
